/* File: design/i2o_queue_pkg.sv */
// Constants for the I2O queue pointer register group.
// Assumes one 100 MHz clock domain and word-wide register accesses.
// Functional notes
// RULE_01: Writing one to bump steps inbound free top.
// RULE_02: Writing one to bump steps inbound post bottom.
// RULE_03: Processor loads post bottom, then only bumps it.
// RULE_04: Each inbound queue write steps post top by four; the code drops the step when a post top load lands in the same cycle.
// RULE_05: Software starts post bottom and top equal.
// RULE_06: Post list empty when bottom equals top.
// RULE_07: Out free bottom steps by four on bump.
// RULE_08: Out free list empty when bottom equals top.
// RULE_09: Base field reads only; offset field read/write.
// RULE_10: Pointed location is base plus offset.
// RULE_11: Size code limits which offset bits increment.
// RULE_12: Offset bits one and zero always read zero.
package i2o_queue_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BASE_W = 12;
    localparam int OFFSET_W = 18;
    localparam int SIZE_W = 3;

    localparam logic [11:0] IN_FREE_TOP_BUMP_OFF = 12'h518;
    localparam logic [11:0] IN_POST_BOTTOM_PTR_OFF = 12'h51c;
    localparam logic [11:0] IN_POST_BOTTOM_BUMP_OFF = 12'h520;
    localparam logic [11:0] IN_POST_TOP_PTR_OFF = 12'h524;
    localparam logic [11:0] OUT_FREE_BOTTOM_PTR_OFF = 12'h528;
    localparam logic [11:0] OUT_FREE_BOTTOM_BUMP_OFF = 12'h52c;

    localparam int STEP_STROBE_BIT = 0;
    localparam int BASE_LSB = 20;
    localparam int ALIGN_BITS = 2;
    localparam logic [17:0] OFFSET_RESET = 18'h00000;
    localparam logic [17:0] STEP_AMOUNT = 18'h00004;
    localparam logic [2:0] SIZE_CODE_MAX = 3'h4;
    localparam int STEP_HI_BASE = 9;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

/* File: design/queue_pointer_cell.sv */
// One queue pointer offset with load and wrap-limited step.
// Assumes load and step are single-cycle strobes from the same clock.
`timescale 1ns/10ps
`default_nettype none
module queue_pointer_cell #(
    parameter int OFFSET_W = 18
) (
    input wire logic clk_i,                   // System clock
    input wire logic rst_i,                   // Synchronous reset, active high
    input wire logic load_i,                  // Load new offset
    input wire logic [OFFSET_W-1:0] load_val_i, // Offset to load
    input wire logic step_i,                  // Advance by one entry
    input wire logic [2:0] size_code_i,       // Queue size code
    output logic [OFFSET_W-1:0] offset_o      // Current offset
);
    // Step mask and alignment assume the 18-bit offset layout
    if (OFFSET_W != i2o_queue_pkg::OFFSET_W) begin : g_bad_width
        $error("queue_pointer_cell supports only the 18-bit offset");
    end

    logic [OFFSET_W-1:0] offset_ff;

    // Mask of bits that may change on a step; codes above the top clamp
    function automatic logic [OFFSET_W-1:0] step_mask(input logic [2:0] code);
        logic [2:0] c;
        logic [OFFSET_W-1:0] m;
        int hi;
        c = (code > i2o_queue_pkg::SIZE_CODE_MAX) ? i2o_queue_pkg::SIZE_CODE_MAX : code;
        hi = i2o_queue_pkg::STEP_HI_BASE + 2 * int'(c);
        m = '0;
        for (int i = i2o_queue_pkg::ALIGN_BITS; i < OFFSET_W; i++) begin
            if (i <= hi) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    logic [OFFSET_W-1:0] mask;
    logic [OFFSET_W-1:0] nxt_step;
    assign mask = step_mask(size_code_i);
    // Upper bits hold still so the pointer wraps inside its circular queue
    assign nxt_step = (offset_ff & ~mask) | ((offset_ff + i2o_queue_pkg::STEP_AMOUNT) & mask); // RULE_11

    // A load wins over a step landing in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            offset_ff <= i2o_queue_pkg::OFFSET_RESET;
        end else if (load_i) begin
            offset_ff <= {load_val_i[OFFSET_W-1:2], 2'b00}; // RULE_12
        end else if (step_i) begin
            offset_ff <= nxt_step;
        end
    end

    assign offset_o = offset_ff;
endmodule
`default_nettype wire

/* File: design/i2o_queue_pointer_regs.sv */
// I2O pointer registers: inbound post bottom/top, outbound free bottom,
// and the bump strobes for inbound free top, inbound post bottom and outbound free bottom.
// Assumes a single-cycle register port in the clk_i domain; base address,
// size code and the foreign top pointer come from neighbouring registers.
`timescale 1ns/10ps
`default_nettype none
module i2o_queue_pointer_regs (
    input wire logic clk_i,                   // System clock, 100 MHz
    input wire logic rst_i,                   // Primary reset, sync, high
    input wire logic [11:0] reg_addr_i,       // Register byte offset
    input wire logic reg_wr_i,                // Register write strobe
    input wire logic reg_rd_i,                // Register read strobe
    input wire logic [31:0] reg_wdata_i,      // Register write data
    output logic [31:0] reg_rdata_o,          // Read data, one cycle later
    input wire logic [11:0] queue_base_address_i, // Queue block base
    input wire logic [2:0] queue_size_i,      // Queue size code
    input wire logic inbound_queue_write_i,   // PCI write to inbound queue
    input wire logic [17:0] out_free_top_offset_i, // Out free top offset
    output logic in_free_top_step_o,          // Step inbound free top
    output logic [31:0] in_post_bottom_addr_o, // Post bottom location
    output logic [31:0] in_post_top_addr_o,   // Post top location
    output logic [31:0] out_free_bottom_addr_o, // Out free bottom location
    output logic in_post_empty_o,             // Inbound post list empty
    output logic out_free_empty_o             // Outbound free list empty
);
    localparam int OW = i2o_queue_pkg::OFFSET_W;

    logic [OW-1:0] in_post_bottom_off;
    logic [OW-1:0] in_post_top_off;
    logic [OW-1:0] out_free_bottom_off;
    logic [31:0] rdata_ff;
    logic wr_bit;

    // Base above, two reserved zero bits, then the offset field
    function automatic logic [31:0] pointer_word(input logic [11:0] base,
                                                 input logic [17:0] off);
        return {base, 2'b00, off};
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    assign wr_bit = reg_wdata_i[i2o_queue_pkg::STEP_STROBE_BIT];

    // Strobe register holds nothing: it only pulses the neighbour pointer
    assign in_free_top_step_o = reg_wr_i && wr_bit &&
        hit(reg_addr_i, i2o_queue_pkg::IN_FREE_TOP_BUMP_OFF); // RULE_01

    queue_pointer_cell #(.OFFSET_W(OW)) u_in_post_bottom (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(reg_wr_i && hit(reg_addr_i, i2o_queue_pkg::IN_POST_BOTTOM_PTR_OFF)), // RULE_03
        .load_val_i(reg_wdata_i[OW-1:0]),
        .step_i(reg_wr_i && wr_bit &&
                hit(reg_addr_i, i2o_queue_pkg::IN_POST_BOTTOM_BUMP_OFF)), // RULE_02
        .size_code_i(queue_size_i),
        .offset_o(in_post_bottom_off)
    );

    queue_pointer_cell #(.OFFSET_W(OW)) u_in_post_top (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(reg_wr_i && hit(reg_addr_i, i2o_queue_pkg::IN_POST_TOP_PTR_OFF)),
        .load_val_i(reg_wdata_i[OW-1:0]),
        .step_i(inbound_queue_write_i), // RULE_04
        .size_code_i(queue_size_i),
        .offset_o(in_post_top_off)
    );

    queue_pointer_cell #(.OFFSET_W(OW)) u_out_free_bottom (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(reg_wr_i && hit(reg_addr_i, i2o_queue_pkg::OUT_FREE_BOTTOM_PTR_OFF)),
        .load_val_i(reg_wdata_i[OW-1:0]),
        .step_i(reg_wr_i && wr_bit &&
                hit(reg_addr_i, i2o_queue_pkg::OUT_FREE_BOTTOM_BUMP_OFF)), // RULE_07
        .size_code_i(queue_size_i),
        .offset_o(out_free_bottom_off)
    );

    // Bump registers and unmapped offsets read back as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_ff <= i2o_queue_pkg::UNMAPPED_READ;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                i2o_queue_pkg::IN_POST_BOTTOM_PTR_OFF: begin
                    rdata_ff <= pointer_word(queue_base_address_i, in_post_bottom_off); // RULE_09
                end
                i2o_queue_pkg::IN_POST_TOP_PTR_OFF: begin
                    rdata_ff <= pointer_word(queue_base_address_i, in_post_top_off); // RULE_09
                end
                i2o_queue_pkg::OUT_FREE_BOTTOM_PTR_OFF: begin
                    rdata_ff <= pointer_word(queue_base_address_i, out_free_bottom_off); // RULE_09
                end
                default: begin
                    rdata_ff <= i2o_queue_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    assign reg_rdata_o = rdata_ff;

    // The 1 MB block base is the high twelve bits, so the sum is a join
    assign in_post_bottom_addr_o = pointer_word(queue_base_address_i, in_post_bottom_off); // RULE_10
    assign in_post_top_addr_o = pointer_word(queue_base_address_i, in_post_top_off); // RULE_10
    assign out_free_bottom_addr_o = pointer_word(queue_base_address_i, out_free_bottom_off); // RULE_10

    // Only meaningful once software has started both pointers equal
    assign in_post_empty_o = (in_post_bottom_off == in_post_top_off); // RULE_06 RULE_05
    assign out_free_empty_o = (out_free_bottom_off == out_free_top_offset_i); // RULE_08
endmodule
`default_nettype wire

/* File: tb/i2o_queue_pointer_regs_chk.sv */
// Checker for the I2O pointer register group.
// Bound to the top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module i2o_queue_pointer_regs_chk (
    input wire logic clk_i, rst_i, reg_wr_i, reg_rd_i, inbound_queue_write_i,
    input wire logic [11:0] reg_addr_i, queue_base_address_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o,
    input wire logic [2:0] queue_size_i,
    input wire logic [17:0] out_free_top_offset_i,
    input wire logic [31:0] in_post_bottom_addr_o, in_post_top_addr_o,
    input wire logic [31:0] out_free_bottom_addr_o,
    input wire logic in_free_top_step_o, in_post_empty_o, out_free_empty_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Largest size code, so a step is a plain add of four
    sequence s_bump(a);
        reg_wr_i && reg_addr_i == a && reg_wdata_i[0] && queue_size_i == 3'h4;
    endsequence
    a_free_step: assert property (in_free_top_step_o ==
        (reg_wr_i && reg_addr_i == 12'h518 && reg_wdata_i[0])) else $error("free step");
    a_bottom_bump: assert property (s_bump(12'h520) |=>
        in_post_bottom_addr_o[17:0] == $past(in_post_bottom_addr_o[17:0]) + 18'h4)
        else $error("post bottom bump");
    a_outfree_bump: assert property (s_bump(12'h52c) |=>
        out_free_bottom_addr_o[17:0] == $past(out_free_bottom_addr_o[17:0]) + 18'h4)
        else $error("free bottom bump");
    a_post_top_step: assert property (inbound_queue_write_i && queue_size_i == 3'h4 &&
        !(reg_wr_i && reg_addr_i == 12'h524) |=>
        in_post_top_addr_o[17:0] == $past(in_post_top_addr_o[17:0]) + 18'h4) else $error("top");
    a_read_top: assert property (reg_rd_i && reg_addr_i == 12'h524 |=>
        reg_rdata_o == $past(in_post_top_addr_o)) else $error("read data");
    a_base_field: assert property (in_post_bottom_addr_o[31:18] ==
        {queue_base_address_i, 2'h0}) else $error("base field");
    a_word_align: assert property (((in_post_bottom_addr_o | in_post_top_addr_o
        | out_free_bottom_addr_o) & 32'h3) == 32'h0) else $error("align");
    a_post_empty: assert property (in_post_empty_o ==
        (in_post_bottom_addr_o == in_post_top_addr_o)) else $error("post empty");
    a_free_empty: assert property (out_free_empty_o ==
        (out_free_bottom_addr_o[17:0] == out_free_top_offset_i)) else $error("free empty");
endmodule
bind i2o_queue_pointer_regs i2o_queue_pointer_regs_chk chk (.*);
`default_nettype wire

/* File: tb/i2o_host_model.sv */
// PCI host side: inbound queue writes and the out free top offset.
// Called from the bench; changes its outputs at falling edges only.
`timescale 1ns/10ps
`default_nettype none
module i2o_host_model (
    input wire logic clk_i,        // System clock
    output logic post_o = 1'b0,    // Inbound queue write pulse
    output logic [17:0] top_o = 18'h0 // Out free top offset
);
    task automatic post(input int n);
        repeat (n) begin
            @(negedge clk_i);
            post_o = 1'b1;
        end
        @(negedge clk_i);
        post_o = 1'b0;
    endtask
    task automatic set_top(input logic [17:0] v);
        @(negedge clk_i);
        top_o = v;
    endtask
endmodule
`default_nettype wire

/* File: tb/i2o_queue_pointer_regs_test.sv */
// Self-checking bench for the I2O pointer register group.
// Reference offsets are plain integers stepped by the size code.
`timescale 1ns/10ps
`default_nettype none
module i2o_queue_pointer_regs_test;
    logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, post, step, pe, fe;
    logic [11:0] adr = 12'h0, base = 12'h0;
    logic [31:0] wd = 32'h0, v, rdat, ba, ta, fa;
    logic [2:0] size = 3'h0;
    logic [17:0] oft;
    int miscompares = 0, n_tests = 0, bottom_offset = 0, top = 0, ofb = 0;
    i2o_host_model host (.clk_i(clk_i), .post_o(post), .top_o(oft));
    i2o_queue_pointer_regs dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(adr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
        .queue_base_address_i(base), .queue_size_i(size), .inbound_queue_write_i(post),
        .out_free_top_offset_i(oft), .in_free_top_step_o(step), .in_post_bottom_addr_o(ba),
        .in_post_top_addr_o(ta), .out_free_bottom_addr_o(fa), .in_post_empty_o(pe),
        .out_free_empty_o(fe));
    function automatic int nx(int o);
        int m = (2 << (9 + 2 * (size > 3'h4 ? 4 : int'(size)))) - 4;
        return (o & ~m) | ((o + 4) & m);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, s);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_all();
        // Let inputs changed at this falling edge settle through the design
        #1;
        chk("post bottom", {base, 2'h0, 18'(bottom_offset)}, ba);
        chk("post top", {base, 2'h0, 18'(top)}, ta);
        chk("free bottom", {base, 2'h0, 18'(ofb)}, fa);
        chk("post empty", 32'(bottom_offset == top), 32'(pe));
        chk("free empty", 32'(ofb == int'(oft)), 32'(fe));
    endtask
    task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk_i);
        wr = w;
        rd = !w;
        adr = a;
        wd = d;
        #1 if (w) chk("free step", 32'(a == 12'h518 && d[0]), 32'(step));
        @(negedge clk_i);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        op(1'b1, a, d);
        case (a)
            12'h51c: bottom_offset = d[17:0] & 18'h3fffc;
            12'h524: top = d[17:0] & 18'h3fffc;
            12'h528: ofb = d[17:0] & 18'h3fffc;
            12'h520: if (d[0]) bottom_offset = nx(bottom_offset);
            12'h52c: if (d[0]) ofb = nx(ofb);
            default: ;
        endcase
        chk_all();
    endtask
    task automatic rreg(input logic [11:0] a, input int o);
        op(1'b0, a, $urandom);
        chk("read", o < 0 ? 32'h0 : {base, 2'h0, 18'(o)}, rdat);
    endtask
    task automatic final_report();
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial forever #5 clk_i = ~clk_i;
    initial begin
        #100us;
        miscompares++;
        final_report();
    end
    initial begin
        void'($urandom(86));
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        chk_all();
        rreg(12'h518, -1);
        rreg(12'h600, -1);
        for (int c = 0; c < 6; c++) begin
            size = 3'(c);
            base = 12'($urandom);
            v = $urandom;
            wreg(12'h51c, v | 32'hfff3ffff);
            wreg(12'h528, v | 32'h0003ffff);
            wreg(12'h524, v);
            rreg(12'h51c, bottom_offset);
            wreg(12'h520, 32'h1);
            wreg(12'h52c, 32'h1);
            wreg(12'h520, 32'h2);
            wreg(12'h518, 32'(c));
            host.post(2);
            top = nx(nx(top));
            chk_all();
            rreg(12'h524, top);
            wreg(12'h524, 32'(bottom_offset));
            host.set_top(18'(ofb));
            chk_all();
            fork
                host.post(1);
                wreg(12'h524, $urandom);
            join
        end
        final_report();
    end
endmodule
`default_nettype wire
